// >>> scr_map.svh
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SCR_OFF_MODE 8'h00
`define SCR_OFF_CTL  8'h04
`define SCR_OFF_TXD  8'h08
`define SCR_OFF_RXD  8'h0C
`define SCR_OFF_FLG  8'h10
`define SCR_OFF_IEN  8'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCR_MODE_LEN_LSB 8
`define SCR_CTL_EN       0
`define SCR_CTL_SRST     1
`define SCR_FLG_BSY      7
`define SCR_FLG_OVR      3
`define SCR_FLG_EOT      2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCR_LEN_RST  4'h7
`define SCR_FLG_RST  4'h1

`endif

// >>> scr_pkg.sv
package scr_pkg;

   // ----------------------------------------
   // Mode fields
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] len;
      logic       pull;
      logic       nodiv;
      logic       lsb;
      logic       clock_phase_sel;
      logic       clock_polarity_sel;
      logic       master_select;
   } scr_mode_t;

   // Flag order matches bits 3..0 of the flag word
   typedef struct packed {
      logic ovr;
      logic eot;
      logic rxf;
      logic txe;
   } scr_flag_t;

   // ----------------------------------------
   // Whole block state
   // ----------------------------------------
   typedef struct packed {
      scr_mode_t   mode;
      logic        en;
      logic        srst;
      logic [3:0]  inte;
      scr_flag_t   flg;
      logic [15:0] txbuf;
      logic [15:0] rxbuf;
      logic [15:0] sh;
      logic        rxbit;
      logic [3:0]  cnt;
      logic        busy;
      logic        sclk;
      logic        sclk_oe_n;
      logic        sdo;
      logic        pull_en;
      logic        irq;
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [3:0]  s3;
      logic [3:0]  f;
      logic [3:0]  fp;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } scr_state_t;

endpackage

// >>> scr_spi_ctrl.sv
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "scr_map.svh"
// Contract
// - End flag sets when word done, buffer empty
// - Receive-full sets on word moved to buffer
// - Transmit-empty sets when buffer enters shifter
// - Overrun sets when word lands on unread
// - Request only for enabled set flags
// - Activity bit 7: master busy, slave selected
// - Word length is length field plus one
// - Pull bit drives input pull enable
// - Master clock undivided or timer half
// - Low bit first selects shift direction
// - Phase and polarity bits shape clock
// - Master bit selects master or slave
// - Mode writes only while unit disabled
// - Soft reset clears shifter, counter, self-clears
// - Unit works only while enabled
// - Sixteen-bit transmit buffer; write starts master
// - Bits above length never shifted out
// - Receive bits above length read zero
// - Enable or soft reset clears receive
// - Transmit-empty resets one, others zero
// - Flags and enables at bits 3..0

module scr_spi_ctrl #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              sys_rst,
   // APB slave
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Serial pins
   input  wire logic              serial_clock_in,
   output logic                   serial_clock_out,
   output logic                   serial_clock_oe_n,
   input  wire logic              serial_in_pin,
   output logic                   serial_out_pin,
   input  wire logic              select_in_pin_n,
   output logic                   input_pull_en,
   // Timer clock and interrupt
   input  wire logic              unit_clock,
   output logic                   irq
);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie in 5..32");
   end

   scr_pkg::scr_state_t r;
   scr_pkg::scr_state_t n;

   logic acc_st;
   logic xfer;
   logic wr;
   logic rd;
   logic h_mode;
   logic h_ctl;
   logic h_txd;
   logic h_rxd;
   logic h_flg;
   logic h_ien;
   logic ssn_f;
   logic sdi_f;
   logic tick;
   logic mst_on;
   logic slv_on;
   logic ev;
   logic lead;
   logic smp;
   logic shf;
   logic last;
   logic wdone;
   logic ld;
   logic act;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Keeps bits up to the configured top bit
   function automatic logic [15:0] lmask(input logic [3:0] l);
      logic [15:0] v;
      v = '0;
      for (int i = 0; i < 16; i++) begin
         v[i] = (i <= int'(l));
      end
      return v;
   endfunction

   // One shift step; new bit lands at the word's own top in LSB mode
   function automatic logic [15:0] shin(input logic [15:0] s, input logic b,
                                        input logic lsb, input logic [3:0] l);
      logic [15:0] v;
      v = lsb ? {1'b0, s[15:1]} : {s[14:0], b};
      if (lsb) begin
         v[l] = b;
      end
      return v;
   endfunction

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // One wait state: answer registered in the first access cycle, shown in the second
   assign acc_st = psel & penable & ~r.pready;
   assign xfer   = psel & penable & r.pready;
   assign wr     = xfer & pwrite;
   assign rd     = xfer & ~pwrite;
   assign h_mode = paddr == ADDR_W'(`SCR_OFF_MODE);
   assign h_ctl  = paddr == ADDR_W'(`SCR_OFF_CTL);
   assign h_txd  = paddr == ADDR_W'(`SCR_OFF_TXD);
   assign h_rxd  = paddr == ADDR_W'(`SCR_OFF_RXD);
   assign h_flg  = paddr == ADDR_W'(`SCR_OFF_FLG);
   assign h_ien  = paddr == ADDR_W'(`SCR_OFF_IEN);

   // ----------------------------------------
   // Serial events
   // ----------------------------------------
   // Filtered pins; raw stages never reach this logic
   assign ssn_f  = r.f[2];
   assign sdi_f  = r.f[1];
   // Undivided runs a full serial clock per timer period
   assign tick   = r.mode.nodiv ? (r.f[3] ^ r.fp[3]) : (r.f[3] & ~r.fp[3]);
   assign mst_on = r.en & r.mode.master_select;
   assign slv_on = r.en & ~r.mode.master_select & ~ssn_f;
   assign ev     = mst_on ? (r.busy & tick) : (slv_on & (r.f[0] ^ r.fp[0]));
   assign lead   = mst_on ? (r.sclk == r.mode.clock_polarity_sel) : (r.fp[0] == r.mode.clock_polarity_sel);
   // Phase 0 samples on the leading edge, phase 1 on the trailing
   assign smp    = ev & (lead ^ r.mode.clock_phase_sel);
   assign shf    = ev & ~(lead ^ r.mode.clock_phase_sel);
   assign last   = r.cnt == r.mode.len;
   assign wdone  = r.mode.clock_phase_sel ? (smp & last) : (shf & last);
   assign ld     = r.en & ~r.flg.txe & (~r.busy | wdone);
   assign act    = r.mode.master_select ? r.busy : ~ssn_f;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      logic [31:0] rv;
      rv = '0;
      n  = r;

      // Three-stage input filter: accept once stages two and three agree
      n.s1 = {unit_clock, select_in_pin_n, serial_in_pin, serial_clock_in};
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.fp = r.f;
      for (int i = 0; i < 4; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            n.f[i] = r.s3[i];
         end
      end

      // Read mux; reserved bits stay zero
      if (h_mode) begin
         rv[11:8] = r.mode.len;
         rv[5:0]  = {r.mode.pull, r.mode.nodiv, r.mode.lsb,
                     r.mode.clock_phase_sel, r.mode.clock_polarity_sel, r.mode.master_select};
      end else if (h_ctl) begin
         rv[1:0] = {r.srst, r.en};
      end else if (h_txd) begin
         rv[15:0] = r.txbuf;
      end else if (h_rxd) begin
         rv[15:0] = r.rxbuf;
      end else if (h_flg) begin
         rv[`SCR_FLG_BSY] = act;
         rv[3:0] = r.flg;
      end else if (h_ien) begin
         rv[3:0] = r.inte;
      end

      // Bus answer: one-cycle ready, error on unmapped address
      n.pready  = 1'b0;
      n.pslverr = 1'b0;
      if (acc_st) begin
         n.pready  = 1'b1;
         n.pslverr = ~(h_mode | h_ctl | h_txd | h_rxd | h_flg | h_ien);
         n.prdata  = rv;
      end

      // Register writes; flag clears come before hardware sets
      if (wr) begin
         if (h_mode) begin
            // Locked while enabled so a running word keeps its format
            if (!r.en) begin
               n.mode.len   = pwdata[11:8];
               n.mode.pull  = pwdata[5];
               n.mode.nodiv = pwdata[4];
               n.mode.lsb   = pwdata[3];
               n.mode.clock_phase_sel  = pwdata[2];
               n.mode.clock_polarity_sel  = pwdata[1];
               n.mode.master_select   = pwdata[0];
            end
         end else if (h_ctl) begin
            n.en = pwdata[`SCR_CTL_EN];
            if (pwdata[`SCR_CTL_SRST]) begin
               n.srst = 1'b1;
            end
            if (pwdata[`SCR_CTL_EN] | pwdata[`SCR_CTL_SRST]) begin
               n.rxbuf = '0;
            end
         end else if (h_txd) begin
            n.txbuf   = pwdata[15:0];
            n.flg.txe = 1'b0;
         end else if (h_flg) begin
            if (pwdata[`SCR_FLG_OVR]) begin
               n.flg.ovr = 1'b0;
            end
            if (pwdata[`SCR_FLG_EOT]) begin
               n.flg.eot = 1'b0;
            end
         end else if (h_ien) begin
            n.inte = pwdata[3:0];
         end
      end
      if (rd && h_rxd) begin
         n.flg.rxf = 1'b0;
      end

      // Sample edge
      if (smp) begin
         n.rxbit = sdi_f;
         if (r.mode.clock_phase_sel) begin
            n.cnt = r.cnt + 4'h1;
            // Last trailing edge shifts at once so the word closes here
            if (last) begin
               n.sh = shin(r.sh, sdi_f, r.mode.lsb, r.mode.len);
            end
         end
      end

      // Shift edge; phase 1 skips the first leading edge
      if (shf) begin
         if (!r.mode.clock_phase_sel) begin
            n.sh  = shin(r.sh, r.rxbit, r.mode.lsb, r.mode.len);
            n.cnt = r.cnt + 4'h1;
         end else if (r.cnt != 4'h0) begin
            n.sh = shin(r.sh, r.rxbit, r.mode.lsb, r.mode.len);
         end
      end
      if (ev && !r.mode.master_select) begin
         n.busy = 1'b1;
      end
      if (mst_on && ev) begin
         n.sclk = ~r.sclk;
      end

      // Word complete
      if (wdone) begin
         n.cnt   = 4'h0;
         n.busy  = 1'b0;
         n.rxbuf = n.sh & lmask(r.mode.len);
         n.flg.rxf = 1'b1;
         if (r.flg.rxf) begin
            n.flg.ovr = 1'b1;
         end
         if (r.flg.txe) begin
            n.flg.eot = 1'b1;
         end
      end

      // Buffer to shifter; a master keeps clocking while words queue
      if (ld) begin
         n.sh      = r.txbuf;
         n.cnt     = 4'h0;
         n.flg.txe = 1'b1;
         if (r.mode.master_select) begin
            n.busy = 1'b1;
         end
      end

      // Deselect drops a partial slave word
      if (r.en && !r.mode.master_select && ssn_f) begin
         n.cnt  = 4'h0;
         n.busy = 1'b0;
      end

      // Soft reset takes one cycle and then clears itself
      if (r.srst) begin
         n.sh    = '0;
         n.cnt   = 4'h0;
         n.busy  = 1'b0;
         n.rxbit = 1'b0;
         n.srst  = 1'b0;
      end

      // Idle clock level follows polarity; disabled master stops
      if (!n.busy) begin
         n.sclk = r.mode.clock_polarity_sel;
      end

      // Pin and interrupt outputs
      // Only bits up to the word's top are ever presented; in phase 1 the
      // data holds across the edge the far side samples on, even at word close
      if (!(smp && r.mode.clock_phase_sel)) begin
         n.sdo = r.mode.lsb ? n.sh[0] : n.sh[r.mode.len];
      end
      n.sclk_oe_n = ~(r.en & r.mode.master_select);
      n.pull_en   = r.mode.pull;
      n.irq       = |(n.flg & n.inte);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         r           <= '0;
         r.mode.len  <= `SCR_LEN_RST;
         r.flg       <= `SCR_FLG_RST;
         r.sclk_oe_n <= 1'b1;
         // Select idles high; a zero here would read as activity after reset
         r.s1        <= 4'h4;
         r.s2        <= 4'h4;
         r.s3        <= 4'h4;
         r.f         <= 4'h4;
         r.fp        <= 4'h4;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register
   assign prdata            = r.prdata;
   assign pready            = r.pready;
   assign pslverr           = r.pslverr;
   assign serial_clock_out  = r.sclk;
   assign serial_clock_oe_n = r.sclk_oe_n;
   assign serial_out_pin    = r.sdo;
   assign input_pull_en     = r.pull_en;
   assign irq               = r.irq;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_eot_on_done: assert property (wdone && r.flg.txe |=> r.flg.eot)
      else $error("end flag missed");
   a_rxf_on_done: assert property (wdone |=> r.flg.rxf && r.cnt == 4'h0)
      else $error("receive flag missed");
   a_txe_write_clr: assert property (wr && h_txd && !r.busy |=> !r.flg.txe ##1 r.flg.txe || !r.en)
      else $error("transmit empty handling wrong");
   a_txe_queued: assert property (wdone && !r.flg.txe && r.en |=> r.flg.txe)
      else $error("queued word not moved to shifter");
   a_ovr_set: assert property (wdone && r.flg.rxf |=> r.flg.ovr)
      else $error("overrun missed");
   a_irq_gate: assert property (!(|(r.flg & r.inte)) |-> !r.irq)
      else $error("request without enabled flag");
   a_mode_lock: assert property (wr && h_mode && r.en |=> $stable(r.mode))
      else $error("mode changed while enabled");
   a_srst_clear: assert property (wr && h_ctl && pwdata[1] |=> r.srst ##1 (!r.srst && r.cnt == 4'h0))
      else $error("soft reset wrong");
   a_rx_upper: assert property (r.en |-> (r.rxbuf & ~lmask(r.mode.len)) == 16'h0000)
      else $error("receive upper bits set");
   a_rx_clear: assert property (wr && h_ctl && (pwdata[0] || pwdata[1]) && !wdone |=> r.rxbuf == 16'h0000)
      else $error("receive not cleared");
   a_apb_ready: assert property (acc_st |=> r.pready ##1 !r.pready)
      else $error("ready timing wrong");
   a_clk_stop: assert property (!r.en ##1 !r.en |-> r.sclk == $past(r.mode.clock_polarity_sel))
      else $error("clock runs while disabled");

   c_master_word: cover property (mst_on && wdone);
   c_slave_word: cover property (slv_on && wdone);
   c_overrun: cover property (wdone && r.flg.rxf);
   c_irq_rise: cover property ($rose(r.irq));

endmodule // scr_spi_ctrl

// >>> scr_spi_peer.sv
`timescale 1ns/1ps
// ----------------------------------------
// Far-side serial peer: slave to the block as master, master to it as slave
// ----------------------------------------
module scr_spi_peer (
   // Shared serial wires
   input  wire logic        sclk_w,
   input  wire logic        sdo,
   output logic             sclk_m,
   output logic             sdi,
   output logic             sel_n,
   // Frame format and data
   input  wire logic        clock_polarity_sel,
   input  wire logic        clock_phase_sel,
   input  wire logic        lsb,
   input  wire logic [4:0]  nbits,
   input  wire logic [15:0] tx_word,
   output logic      [15:0] rx_word
);
   int          sidx;
   logic        armed;
   logic [15:0] acc;

   // Bit position of the n-th bit of a word on the wire
   function automatic int pos(input int n);
      return lsb ? n : nbits - 1 - n;
   endfunction

   initial begin
      sclk_m = 1'b0;
      sdi = 1'b1;
      sel_n = 1'b1;
      armed = 1'b0;
      sidx = 0;
      acc = 16'h0000;
      rx_word = 16'h0000;
   end

   // Sample on one edge, shift on the other; the count wraps per word
   always @(sclk_w) begin
      if (armed) begin
         if ((sclk_w != clock_polarity_sel) != clock_phase_sel) begin
            acc[pos(sidx)] = sdo;
            sidx = sidx + 1;
            if (sidx == nbits) begin
               rx_word = acc;
               sidx = 0;
            end
         end else begin
            sdi = tx_word[pos(sidx)];
         end
      end
   end

   // First bit must stand before the first sample edge
   task automatic arm;
      armed = 1'b1;
      acc = 16'h0000; // Bits above a shorter word must not linger
      sidx = 0;
      sdi = tx_word[pos(0)];
   endtask

   // One selected frame of n bits; the clock stands still outside it
   task automatic xfer(input int n);
      sclk_m = clock_polarity_sel;
      sel_n = 1'b0;
      arm();
      #1200;
      repeat (n) begin
         #800 sclk_m = ~clock_polarity_sel;
         #800 sclk_m = clock_polarity_sel;
      end
      #800;
      sel_n = 1'b1;
      sdi = ~sdi; // Released line must not keep its last bit
   endtask
endmodule // scr_spi_peer

// >>> scr_spi_ctrl_tb.sv
`timescale 1ns/1ps
`include "scr_map.svh"
module scr_spi_ctrl_tb;
   typedef struct packed {
      logic [31:0] exp;
      logic [31:0] m;
      logic        err;
   } scr_note_t;

   localparam logic [31:0] FULL = 32'hFFFFFFFF;
   localparam logic [3:0]  LENS [4] = '{4'h7, 4'hF, 4'h1, 4'hB};

   logic        ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, mode;
   logic        sclk_o, sclk_oe_n, sclk_m, sdi, sdo, sel_n, pull_en, unit_clock, irq;
   wire         sclk_w;
   logic        clock_polarity_sel, clock_phase_sel, lsb;
   logic [4:0]  nbits;
   logic [15:0] ptx, prx, d, msk;
   logic [3:0]  len;
   scr_note_t   notes[$];
   scr_note_t   nt;
   int          err_count = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          seed, p;
   realtime     t0;

   // Clock pin level follows whoever has the driver enabled
   assign sclk_w = sclk_oe_n ? sclk_m : sclk_o;

   scr_spi_ctrl #(.ADDR_W(8)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_clock_in(sclk_w), .serial_clock_out(sclk_o),
      .serial_clock_oe_n(sclk_oe_n), .serial_in_pin(sdi), .serial_out_pin(sdo),
      .select_in_pin_n(sel_n), .input_pull_en(pull_en), .unit_clock(unit_clock), .irq(irq));

   scr_spi_peer peer (.sclk_w(sclk_w), .sdo(sdo), .sclk_m(sclk_m), .sdi(sdi), .sel_n(sel_n),
      .clock_polarity_sel(clock_polarity_sel), .clock_phase_sel(clock_phase_sel), .lsb(lsb), .nbits(nbits), .tx_word(ptx), .rx_word(prx));

   // ----------------------------------------
   // Clocks and watchdog
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Timer output, phase unrelated to the system clock
   initial begin
      unit_clock = 1'b0;
      #37;
      forever #400 unit_clock = ~unit_clock;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Checking
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Each completed bus transfer consumes the oldest note
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1) begin
         nt = notes.pop_front();
         chk("prdata", nt.exp & nt.m, prdata & nt.m);
         chk("pslverr", 32'(nt.err), 32'(pslverr));
      end
   end

   task automatic end_sim;
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------
   // Bus master
   // ----------------------------------------
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt, input logic [31:0] m,
                      input logic e);
      notes.push_back('{dt, wr ? 32'h0 : m, e});
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dt;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic w(input logic [7:0] a, input logic [31:0] dt);
      apb(1'b1, a, dt, 32'h0, 1'b0);
   endtask

   task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, a, e, m, 1'b0);
   endtask

   task automatic wait_irq;
      for (int t = 0; t < 3000 && irq !== 1'b1; t++) @(posedge ref_clk);
      chk("irq", 32'h1, 32'(irq));
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      sys_rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {clock_polarity_sel, clock_phase_sel, lsb, nbits, ptx} = {3'b000, 5'd8, 16'h0000};
      seed = $urandom(32'h288349E3);
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      r(`SCR_OFF_MODE, 32'h0700, FULL);
      r(`SCR_OFF_CTL, 32'h0, FULL);
      r(`SCR_OFF_TXD, 32'h0, FULL);
      r(`SCR_OFF_RXD, 32'h0, FULL);
      r(`SCR_OFF_FLG, 32'h01, FULL);
      r(`SCR_OFF_IEN, 32'h0, FULL);
      apb(1'b0, 8'h18, 32'h0, FULL, 1'b1);
      w(`SCR_OFF_MODE, FULL);
      r(`SCR_OFF_MODE, 32'h0F3F, FULL);
      chk("pull", 32'h1, 32'(pull_en));
      w(`SCR_OFF_MODE, 32'h0700);
      w(`SCR_OFF_FLG, FULL);
      r(`SCR_OFF_FLG, 32'h01, FULL);
      chk("pull", 32'h0, 32'(pull_en));
      chk("irq", 32'h0, 32'(irq));
      w(`SCR_OFF_IEN, FULL);
      r(`SCR_OFF_IEN, 32'h0F, FULL);
      chk("irq", 32'h1, 32'(irq));
      w(`SCR_OFF_IEN, 32'h4);
      r(`SCR_OFF_IEN, 32'h4, FULL);
      chk("irq", 32'h0, 32'(irq));
      // Master words in all four clock shapes, both bit orders, lengths of 8, 16, 2 and 12 bits
      for (int i = 0; i < 4; i++) begin
         len = LENS[i];
         {clock_polarity_sel, clock_phase_sel, lsb} = {i[0], i[1], i[0] ^ i[1]};
         nbits = {1'b0, len} + 5'd1;
         msk = 16'hFFFF >> (4'hF - len);
         mode = {20'h0, len, 4'h0, lsb, clock_phase_sel, clock_polarity_sel, 1'b1};
         d = 16'($urandom);
         ptx = 16'($urandom);
         w(`SCR_OFF_CTL, 32'h0);
         w(`SCR_OFF_MODE, mode);
         w(`SCR_OFF_CTL, 32'h3);
         r(`SCR_OFF_CTL, 32'h1, FULL);
         r(`SCR_OFF_RXD, 32'h0, FULL);
         peer.arm();
         w(`SCR_OFF_TXD, {16'h0, d});
         wait_irq();
         chk("peer rx", {16'h0, d & msk}, {16'h0, prx});
         r(`SCR_OFF_FLG, 32'h07, FULL);
         r(`SCR_OFF_RXD, {16'h0, ptx & msk}, FULL);
         w(`SCR_OFF_FLG, 32'h4);
         r(`SCR_OFF_FLG, 32'h01, FULL);
         chk("irq", 32'h0, 32'(irq));
      end
      // Queued second word while shifting, unread first word overruns
      d = 16'($urandom);
      peer.arm();
      w(`SCR_OFF_TXD, 32'h5A5A);
      w(`SCR_OFF_TXD, {16'h0, d});
      wait_irq();
      chk("peer rx", {16'h0, d & msk}, {16'h0, prx});
      r(`SCR_OFF_FLG, 32'h0F, FULL);
      w(`SCR_OFF_FLG, 32'h8);
      r(`SCR_OFF_FLG, 32'h07, FULL);
      w(`SCR_OFF_MODE, 32'h0);
      r(`SCR_OFF_MODE, mode, FULL);
      w(`SCR_OFF_FLG, 32'h4);
      r(`SCR_OFF_RXD, {16'h0, ptx & msk}, FULL);
      // Serial clock rate from the timer, divided and undivided
      for (int nd = 0; nd < 2; nd++) begin
         w(`SCR_OFF_CTL, 32'h0);
         w(`SCR_OFF_MODE, 32'h0701 | (nd << 4));
         chk("clock oe_n", 32'h1, 32'(sclk_oe_n));
         w(`SCR_OFF_CTL, 32'h3);
         w(`SCR_OFF_TXD, $urandom);
         @(posedge sclk_o);
         t0 = $realtime;
         @(posedge sclk_o);
         p = int'($realtime - t0);
         chk("clock period", nd ? 800 : 1600, p);
         chk("clock oe_n", 32'h0, 32'(sclk_oe_n));
         wait_irq();
         w(`SCR_OFF_FLG, 32'hC);
         r(`SCR_OFF_RXD, 32'h0, 32'h0);
      end
      // Slave word clocked by the peer
      {clock_polarity_sel, clock_phase_sel, lsb, nbits} = {3'b000, 5'd8};
      ptx = 16'($urandom);
      d = 16'($urandom);
      w(`SCR_OFF_CTL, 32'h0);
      w(`SCR_OFF_MODE, 32'h0700);
      w(`SCR_OFF_CTL, 32'h3);
      w(`SCR_OFF_TXD, {16'h0, d});
      fork
         peer.xfer(8);
         begin
            repeat (30) @(posedge ref_clk);
            r(`SCR_OFF_FLG, 32'h80, 32'h80);
         end
      join
      repeat (10) @(posedge ref_clk);
      chk("peer rx", {16'h0, d & 16'h00FF}, {16'h0, prx});
      chk("clock oe_n", 32'h1, 32'(sclk_oe_n));
      r(`SCR_OFF_RXD, {16'h0, ptx & 16'h00FF}, FULL);
      r(`SCR_OFF_FLG, 32'h0, 32'h80);
      w(`SCR_OFF_CTL, 32'h0);
      end_sim();
   end
endmodule // scr_spi_ctrl_tb
